// ---- bench/sbs_host.sv ----
`default_nettype none
module sbs_host (
  // Clock and bus answer.
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Holds each phase until ready is seen high; released write data is inverted.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do
      @(posedge hclk);
    while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do
      @(posedge hclk);
    while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask : xfer
endmodule : sbs_host
`default_nettype wire

// ---- bench/sbs_properties.sv ----
`include "sbs_map.svh"
`default_nettype none
module sbs_properties (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // Bus answer and fault report.
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic fault_valid,
  input wire logic [1:0] fault_kind,
  input wire logic fault_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic [3:0] age;
  logic [3:0] next_age;
  assign take = hsel && htrans[1] && hready;
  // Counts cycles since the last command write.
  always_comb
  begin
    next_age = (age == 4'hf) ? age : age + 4'h1;
    if (take && hwrite && haddr[7:0] == `A_CMD)
      next_age = 4'h0;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      age <= 4'hf;
    else
      age <= next_age;
  end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_ready_high: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  a_rdata_holds: assert property ($changed(hrdata) |-> $past(take && !hwrite))
    else $error("read data moved without a read");
  a_fault_pulse: assert property (fault_valid |=> !fault_valid)
    else $error("fault pulse too long");
  a_fault_cause: assert property (fault_valid |-> age inside {[1:5]})
    else $error("fault without a command");
  a_kind_named: assert property (fault_valid |-> ##[0:1] fault_kind != sbs_pkg::FK_NONE)
    else $error("fault kind missing");
  a_kind_quiet: assert property ($changed(fault_kind) |-> age inside {[1:5]})
    else $error("fault kind moved alone");
  a_gp_code: assert property (fault_valid && fault_kind == sbs_pkg::FK_GP |-> fault_err)
    else $error("protection fault without code");
  a_ac_code: assert property (fault_valid && fault_kind == sbs_pkg::FK_AC |-> fault_err)
    else $error("alignment fault without code");
endmodule : sbs_properties
`default_nettype wire

// ---- bench/shift_borrow_scan_alu_bench.sv ----
`include "sbs_map.svh"
`default_nettype none
`define CHK(nm, e, a) \
  total_checks++; \
  if ((a) !== (e)) \
  begin \
    $display("[FAIL] %s exp %h got %h", nm, e, a); \
    n_mismatch++; \
  end
module shift_borrow_scan_alu_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, fault_valid, fault_err;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, fault_kind;
  logic [2:0] hsize;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int nfv = 0;
  logic [7:0] opc [9] = '{8'h1c, 8'h1d, 8'h80, 8'h81, 8'h83, 8'h18, 8'h19, 8'h1a, 8'h1b};
  logic [31:0] envt [7] = '{32'h81, 32'h41, 32'h100, 32'h101, 32'h1d, 32'h21, 32'h1};
  logic [2:0] expt [7] = '{3'h5, 3'h5, 3'h2, 3'h6, 3'h7, 3'h5, 3'h5};
  always #25 hclk = ~hclk;
  sbs_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  shift_borrow_scan_alu i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_err(fault_err));
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  // Counts fault pulses and cuts a hang short.
  always @(posedge hclk)
  begin
    cyc++;
    if (fault_valid === 1'b1)
      nfv++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_host.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_host.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    `CHK($sformatf("reg %h", a), e & m, v & m)
  endtask : chk_reg
  task automatic poll(input int b, input logic v);
    logic [31:0] s;
    int t;
    t = 0;
    repeat (2) @(posedge hclk);
    do
      rd(`A_STATUS, s);
    while (s[b] !== v && ++t < 200);
    `CHK("status", v, s[b])
  endtask : poll
  function automatic logic [31:0] wmask(input logic [1:0] sz);
    return (sz == 2'h0) ? 32'hff : (sz == 2'h1) ? 32'hffff : 32'hffffffff;
  endfunction : wmask
  function automatic logic [31:0] subf(input logic [31:0] x, input logic [31:0] y, input logic c,
    input logic [1:0] sz);
    logic [31:0] m, r, t, f;
    int w;
    m = wmask(sz);
    w = 8 << sz;
    x = x & m;
    y = y & m;
    r = (x - y - c) & m;
    t = (x ^ y) & (x ^ r);
    f = 32'h0;
    f[0] = {1'b0, x} < ({1'b0, y} + c);
    f[11] = t[w - 1];
    f[4] = x[4] ^ y[4] ^ r[4];
    f[6] = (r == 32'h0);
    f[7] = r[w - 1];
    f[2] = ~^r[7:0];
    return f;
  endfunction : subf
  initial
  begin
    logic [31:0] a, d, s, f, fm, m, r, v, x;
    logic [2:0] op;
    logic [1:0] sz;
    logic [7:0] o;
    int n, w, k, j;
    void'($urandom(32'h7fe2));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`A_FLAGS, v);
    `CHK("flags reset", `FLAGS_RST, v)
    for (k = 0; k < 24; k++)
    begin
      op = 3'($urandom_range(2));
      sz = 2'($urandom_range(2));
      d = $urandom;
      s = (k < 4) ? 32'(k[0] + 32 * k[1]) : $urandom_range(255);
      f = $urandom & 32'h8d5;
      wr(`A_ENV, $urandom & 32'h3);
      wr(`A_FLAGS, f);
      wr(`A_DEST, d);
      wr(`A_SRC, s);
      wr(`A_CMD, {27'h0, sz, op});
      poll(0, 1'b0);
      m = wmask(sz);
      w = 8 << sz;
      n = s[4:0];
      r = d & m;
      fm = 32'h8c5;
      for (j = 0; j < n; j++)
      begin
        f[0] = (op == 3'h0) ? r[w - 1] : r[0];
        r = (op == 3'h0) ? (r << 1) & m : (r >> 1) | ((op == 3'h1) ? r & (32'h1 << (w - 1)) : 32'h0);
      end
      if (n == 1)
        f[11] = (op == 3'h0) ? r[w - 1] ^ f[0] : (op == 3'h2) & d[w - 1];
      if (n != 0)
      begin
        f[2] = ~^r[7:0];
        f[6] = (r == 32'h0);
        f[7] = r[w - 1];
      end
      if (op != 3'h1 && n >= w)
        fm[0] = 1'b0;
      chk_reg(`A_DEST, m, r);
      chk_reg(`A_FLAGS, fm, f);
    end
    $display("shift test done");
    for (k = 0; k < 18; k++)
    begin
      o = opc[k % 9];
      sz = (o inside {8'h1c, 8'h80, 8'h18, 8'h1a}) ? 2'h0 : 2'($urandom_range(2, 1));
      d = $urandom;
      a = $urandom;
      s = k[0] ? 32'hff : $urandom;
      f = 32'($urandom_range(1));
      wr(`A_DEST, d);
      wr(`A_ACC, a);
      wr(`A_SRC, s);
      wr(`A_FLAGS, f);
      wr(`A_CMD, {13'h0, 3'h3, o, 3'h0, sz, 3'h3});
      poll(0, 1'b0);
      x = (o == 8'h1c || o == 8'h1d) ? a : d;
      if (o == 8'h83)
        s = {{24{s[7]}}, s[7:0]};
      chk_reg(`A_STATUS, 32'h4, 32'h0);
      chk_reg((o == 8'h1c || o == 8'h1d) ? `A_ACC : `A_DEST, wmask(sz), x - s - f[0]);
      chk_reg(`A_FLAGS, 32'h8d5, subf(x, s, f[0], sz));
    end
    wr(`A_CMD, {13'h0, 3'h2, 8'h81, 8'h13});
    poll(0, 1'b0);
    chk_reg(`A_STATUS, 32'h4, 32'h4);
    $display("borrow test done");
    wr(`A_ENV, 32'h0);
    wr(`A_ESLIM, 32'hffffffff);
    for (k = 0; k < 6; k++)
    begin
      sz = 2'(k % 3);
      a = $urandom;
      d = (k == 0) ? 32'h1234ffff : $urandom;
      f = 32'(k[0]) << 10;
      n = (k > 2) ? 3 : 1;
      wr(`A_ACC, a);
      wr(`A_DIDX, d);
      wr(`A_COUNT, n);
      wr(`A_FLAGS, f);
      wr(`A_CMD, {24'h0, k == 0, k > 2, 1'b0, sz, 3'h4});
      for (j = 0; j < n; j++)
      begin
        poll(1, 1'b1);
        s = $urandom;
        wr(`A_MEM, s);
        f = subf(a, s, 1'b0, sz) | (f & 32'h400);
        x = k[0] ? -(32'h1 << sz) : (32'h1 << sz);
        d = (k == 0) ? {d[31:16], d[15:0] + x[15:0]} : d + x;
      end
      poll(0, 1'b0);
      chk_reg(`A_FLAGS, 32'hcd5, f);
      chk_reg(`A_DIDX, 32'hffffffff, d);
      chk_reg(`A_COUNT, 32'hffffffff, (k > 2) ? 32'h0 : 32'h1);
      chk_reg(`A_ACC, 32'hffffffff, a);
    end
    wr(`A_COUNT, 32'h0);
    wr(`A_CMD, 32'h44);
    poll(0, 1'b0);
    chk_reg(`A_DIDX, 32'hffffffff, d);
    $display("scan test done");
    wr(`A_SSLIM, 32'h0);
    wr(`A_ESLIM, 32'h0);
    wr(`A_MADDR, 32'h1);
    wr(`A_SRC, 32'h1);
    for (k = 0; k < 7; k++)
    begin
      d = $urandom;
      f = $urandom & 32'h8d5;
      wr(`A_DEST, d);
      wr(`A_FLAGS, f);
      wr(`A_DIDX, (k == 6) ? 32'h8 : 32'h0);
      wr(`A_ENV, envt[k]);
      j = nfv;
      wr(`A_CMD, (k > 4) ? 32'h14 : k[0] ? 32'h38133 : 32'h30);
      if (k > 4)
      begin
        wr(`A_MEM, 32'h0);
      end
      poll(0, 1'b0);
      chk_reg(`A_STATUS, 32'h38, {26'h0, expt[k], 3'h0});
      `CHK("fault pulse", j + 1, nfv)
      `CHK("fault port", expt[k], {fault_err, fault_kind})
      chk_reg(`A_DEST, 32'hffffffff, d);
      chk_reg(`A_FLAGS, 32'h8d5, f);
      chk_reg(`A_DIDX, 32'hffffffff, (k == 6) ? 32'h8 : 32'h0);
    end
    $display("fault test done");
    give_verdict();
  end
endmodule : shift_borrow_scan_alu_bench
bind shift_borrow_scan_alu sbs_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .fault_valid(fault_valid), .fault_kind(fault_kind), .fault_err(fault_err));
`default_nettype wire

// ---- rtl/sbs_map.svh ----
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH
// Register byte addresses.
`define A_CMD 8'h00
`define A_DEST 8'h04
`define A_SRC 8'h08
`define A_ACC 8'h0c
`define A_DIDX 8'h10
`define A_COUNT 8'h14
`define A_FLAGS 8'h18
`define A_ENV 8'h1c
`define A_ESLIM 8'h20
`define A_SSLIM 8'h24
`define A_MADDR 8'h28
`define A_MEM 8'h2c
`define A_STATUS 8'h30
// Flags register bit positions.
`define F_CF 0
`define F_PF 2
`define F_AF 4
`define F_ZF 6
`define F_SF 7
`define F_DF 10
`define F_OF 11
// Environment bit positions.
`define E_PMODE 0
`define E_V86 1
`define E_ACEN 2
`define E_CPL_LO 3
`define E_ESNULL 5
`define E_DSNULL 6
`define E_SEGRO 7
`define E_USESS 8
// Reset values and constants.
`define FLAGS_RST 32'h00000000
`define CNT_MASK 5'h1f
`define CPL_USER 2'h3
`define OPC_ACC8 8'h1c
`define OPC_ACC 8'h1d
`define OPC_GRP8 8'h80
`define OPC_GRP 8'h81
`define OPC_GRPS8 8'h83
`define OPC_RR_LO 8'h18
`define OPC_RR_HI 8'h1b
`define REG_SBB 3'h3
`endif

// ---- rtl/sbs_pkg.sv ----
`default_nettype none
package sbs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_SCAN = 4'b1000
  } state_t;
  typedef enum logic [2:0] {
    OP_SHL = 3'h0,
    OP_SAR = 3'h1,
    OP_SHR = 3'h2,
    OP_SBB = 3'h3,
    OP_SCAN = 3'h4
  } op_t;
  typedef enum logic [1:0] {
    FK_NONE = 2'h0,
    FK_GP = 2'h1,
    FK_SS = 2'h2,
    FK_AC = 2'h3
  } fault_t;
endpackage : sbs_pkg
`default_nettype wire

// ---- rtl/shift_borrow_scan_alu.sv ----
// Design decisions made here: the register addresses and register access over AHB-Lite.
`include "sbs_map.svh"
`default_nettype none
module shift_borrow_scan_alu (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Exception report.
  output logic fault_valid,
  output logic [1:0] fault_kind,
  output logic fault_err
);
  sbs_pkg::state_t st, next_st;
  logic [7:0] wa, next_wa;
  logic wv, next_wv;
  logic [31:0] next_hrdata;
  logic [2:0] op, next_op;
  logic [1:0] sz, next_sz;
  logic memd, next_memd;
  logic iterate_prefix, next_rep;
  logic a16, next_a16;
  logic sext, next_sext;
  logic accd, next_accd;
  logic bad, next_bad;
  logic [31:0] dest, next_dest;
  logic [31:0] src, next_src;
  logic [31:0] acc, next_acc;
  logic [31:0] didx, next_didx;
  logic [31:0] cnt, next_cnt;
  logic [31:0] flags, next_flags;
  logic [8:0] env, next_env;
  logic [31:0] eslim, next_eslim;
  logic [31:0] sslim, next_sslim;
  logic [31:0] maddr, next_maddr;
  logic [31:0] tmp, next_tmp;
  logic [4:0] sc, next_sc;
  logic next_fv;
  logic [1:0] next_fk;
  logic next_fe;
  logic [31:0] m;
  logic [4:0] msbi;
  logic [31:0] sa, sb, res, srcx, sh, saddr;
  logic [32:0] r33;
  logic cin, brw, ovf, afl, shc, sbb_ok, mis, scflt;
  logic [7:0] opc;
  logic [1:0] msz;
  logic [2:0] opb;
  logic [31:0] step;

  // Operand width, mask and top bit index.
  always_comb
  begin
    m = 32'hffffffff;
    msbi = 5'd31;
    if (sz == 2'h0)
    begin
      m = 32'h000000ff;
      msbi = 5'd7;
    end
    else if (sz == 2'h1)
    begin
      m = 32'h0000ffff;
      msbi = 5'd15;
    end
  end

  // Shared subtractor for borrow subtract and scan.
  always_comb
  begin
    srcx = sext ? {{24{src[7]}}, src[7:0]} : src;
    if (st == sbs_pkg::ST_SCAN)
    begin
      sa = acc & m;
      sb = hwdata & m;
      cin = 1'b0;
    end
    else
    begin
      sa = (accd ? acc : dest) & m;
      sb = srcx & m;
      cin = flags[`F_CF];
    end
    r33 = {1'b0, sa} - {1'b0, sb} - {32'h0, cin};
    res = r33[31:0] & m;
    brw = r33[msbi + 5'd1];
    if (msbi == 5'd31)
    begin
      brw = r33[32];
    end
    ovf = (sa[msbi] ^ sb[msbi]) & (res[msbi] ^ sa[msbi]);
    afl = sa[4] ^ sb[4] ^ res[4];
  end

  // One shift step.
  always_comb
  begin
    if (op == sbs_pkg::OP_SHL)
    begin
      shc = tmp[msbi];
      sh = (tmp << 1) & m;
    end
    else
    begin
      shc = tmp[0];
      sh = tmp >> 1;
      if (op == sbs_pkg::OP_SAR)
      begin
        sh[msbi] = tmp[msbi];
      end
    end
  end

  // Opcode decode of a command write.
  always_comb
  begin
    opc = hwdata[15:8];
    opb = hwdata[18:16];
    msz = hwdata[4:3];
    sbb_ok = (opc == `OPC_ACC8) || (opc == `OPC_ACC)
      || (((opc == `OPC_GRP8) || (opc == `OPC_GRP) || (opc == `OPC_GRPS8)) && (opb == `REG_SBB))
      || ((opc >= `OPC_RR_LO) && (opc <= `OPC_RR_HI));
    if ((opc == `OPC_ACC8) || (opc == `OPC_GRP8) || (opc == `OPC_RR_LO) || (opc == 8'h1a))
    begin
      msz = 2'h0;
    end
  end

  // Address checks for memory operands.
  always_comb
  begin
    saddr = a16 ? {16'h0, didx[15:0]} : didx;
    if (st == sbs_pkg::ST_EXEC)
    begin
      saddr = maddr;
    end
    mis = ((sz == 2'h1) && saddr[0]) || ((sz == 2'h2) && (saddr[1:0] != 2'h0));
    mis = mis && env[`E_ACEN] && (env[`E_CPL_LO +: 2] == `CPL_USER);
    scflt = env[`E_ESNULL] || (saddr > eslim);
    step = (sz == 2'h0) ? 32'h1 : ((sz == 2'h1) ? 32'h2 : 32'h4);
  end

  // Bus address phase capture and read data.
  always_comb
  begin
    next_wa = haddr[7:0];
    next_wv = hsel && htrans[1] && hready && hwrite;
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      case (haddr[7:0])
        `A_CMD: next_hrdata = {23'h0, accd, a16, iterate_prefix, memd, sz, op};
        `A_DEST: next_hrdata = dest;
        `A_SRC: next_hrdata = src;
        `A_ACC: next_hrdata = acc;
        `A_DIDX: next_hrdata = didx;
        `A_COUNT: next_hrdata = cnt;
        `A_FLAGS: next_hrdata = flags;
        `A_ENV: next_hrdata = {23'h0, env};
        `A_ESLIM: next_hrdata = eslim;
        `A_SSLIM: next_hrdata = sslim;
        `A_MADDR: next_hrdata = maddr;
        `A_STATUS: next_hrdata = {26'h0, fault_err, fault_kind, bad, st == sbs_pkg::ST_SCAN, st != sbs_pkg::ST_IDLE};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // Command engine and register file.
  always_comb
  begin
    next_st = st;
    next_op = op;
    next_sz = sz;
    next_memd = memd;
    next_rep = iterate_prefix;
    next_a16 = a16;
    next_sext = sext;
    next_accd = accd;
    next_bad = bad;
    next_dest = dest;
    next_src = src;
    next_acc = acc;
    next_didx = didx;
    next_cnt = cnt;
    next_flags = flags;
    next_env = env;
    next_eslim = eslim;
    next_sslim = sslim;
    next_maddr = maddr;
    next_tmp = tmp;
    next_sc = sc;
    next_fv = 1'b0;
    next_fk = fault_kind;
    next_fe = fault_err;
    case (st)
      sbs_pkg::ST_IDLE:
      begin
        if (wv)
        begin
          case (wa)
            `A_DEST: next_dest = hwdata;
            `A_SRC: next_src = hwdata;
            `A_ACC: next_acc = hwdata;
            `A_DIDX: next_didx = hwdata;
            `A_COUNT: next_cnt = hwdata;
            `A_FLAGS: next_flags = hwdata;
            `A_ENV: next_env = hwdata[8:0];
            `A_ESLIM: next_eslim = hwdata;
            `A_SSLIM: next_sslim = hwdata;
            `A_MADDR: next_maddr = hwdata;
            `A_CMD:
            begin
              next_op = hwdata[2:0];
              next_sz = hwdata[4:3];
              next_memd = hwdata[5];
              next_rep = hwdata[6];
              next_a16 = hwdata[7];
              next_sext = 1'b0;
              next_accd = 1'b0;
              next_bad = 1'b0;
              next_st = sbs_pkg::ST_EXEC;
              if (hwdata[2:0] == sbs_pkg::OP_SBB)
              begin
                next_sz = msz;
                next_sext = (opc == `OPC_GRPS8);
                next_accd = (opc == `OPC_ACC8) || (opc == `OPC_ACC);
                next_memd = hwdata[5] && !next_accd;
                if (!sbb_ok)
                begin
                  next_bad = 1'b1;
                  next_st = sbs_pkg::ST_IDLE;
                end
              end
              else if (hwdata[2:0] > sbs_pkg::OP_SCAN)
              begin
                next_bad = 1'b1;
                next_st = sbs_pkg::ST_IDLE;
              end
            end
            default: next_st = sbs_pkg::ST_IDLE;
          endcase
        end
      end
      sbs_pkg::ST_EXEC:
      begin
        next_st = sbs_pkg::ST_IDLE;
        next_fk = sbs_pkg::FK_NONE;
        next_fe = 1'b0;
        if (op == sbs_pkg::OP_SCAN)
        begin
          if (!(iterate_prefix && (cnt == 32'h0)))
          begin
            next_st = sbs_pkg::ST_SCAN;
          end
        end
        else if (memd && env[`E_PMODE] && env[`E_SEGRO])
        begin
          next_fv = 1'b1;
          next_fk = sbs_pkg::FK_GP;
          next_fe = 1'b1;
        end
        else if (memd && env[`E_PMODE] && !env[`E_USESS] && env[`E_DSNULL])
        begin
          next_fv = 1'b1;
          next_fk = sbs_pkg::FK_GP;
          next_fe = 1'b1;
        end
        else if (memd && env[`E_USESS] && (maddr > sslim))
        begin
          next_fv = 1'b1;
          next_fk = sbs_pkg::FK_SS;
          next_fe = env[`E_PMODE] || env[`E_V86];
        end
        else if (memd && mis)
        begin
          next_fv = 1'b1;
          next_fk = sbs_pkg::FK_AC;
          next_fe = 1'b1;
        end
        else if (op == sbs_pkg::OP_SBB)
        begin
          if (accd)
          begin
            next_acc = (acc & ~m) | res;
          end
          else
          begin
            next_dest = (dest & ~m) | res;
          end
          next_flags[`F_CF] = brw;
          next_flags[`F_OF] = ovf;
          next_flags[`F_SF] = res[msbi];
          next_flags[`F_ZF] = (res == 32'h0);
          next_flags[`F_AF] = afl;
          next_flags[`F_PF] = ~^res[7:0];
        end
        else
        begin
          next_sc = src[4:0] & `CNT_MASK;
          next_tmp = dest & m;
          if ((src[4:0] & `CNT_MASK) != 5'h0)
          begin
            next_st = sbs_pkg::ST_SHIFT;
          end
        end
      end
      sbs_pkg::ST_SHIFT:
      begin
        next_tmp = sh;
        next_sc = sc - 5'd1;
        next_flags[`F_CF] = shc;
        if (sc == 5'd1)
        begin
          next_st = sbs_pkg::ST_IDLE;
          next_dest = (dest & ~m) | sh;
          next_flags[`F_SF] = sh[msbi];
          next_flags[`F_ZF] = (sh == 32'h0);
          next_flags[`F_PF] = ~^sh[7:0];
          if ((src[4:0] & `CNT_MASK) == 5'd1)
          begin
            case (op)
              sbs_pkg::OP_SHL: next_flags[`F_OF] = sh[msbi] ^ shc;
              sbs_pkg::OP_SAR: next_flags[`F_OF] = 1'b0;
              default: next_flags[`F_OF] = dest[msbi];
            endcase
          end
        end
      end
      sbs_pkg::ST_SCAN:
      begin
        if (wv && (wa == `A_MEM))
        begin
          if (scflt || mis)
          begin
            next_fv = 1'b1;
            next_fk = scflt ? sbs_pkg::FK_GP : sbs_pkg::FK_AC;
            next_fe = 1'b1;
            next_st = sbs_pkg::ST_IDLE;
          end
          else
          begin
            next_flags[`F_CF] = brw;
            next_flags[`F_OF] = ovf;
            next_flags[`F_SF] = res[msbi];
            next_flags[`F_ZF] = (res == 32'h0);
            next_flags[`F_AF] = afl;
            next_flags[`F_PF] = ~^res[7:0];
            if (flags[`F_DF])
            begin
              next_didx = didx - step;
            end
            else
            begin
              next_didx = didx + step;
            end
            if (a16)
            begin
              next_didx = {didx[31:16], next_didx[15:0]};
            end
            next_st = sbs_pkg::ST_IDLE;
            if (iterate_prefix)
            begin
              next_cnt = cnt - 32'h1;
              if (cnt != 32'h1)
              begin
                next_st = sbs_pkg::ST_SCAN;
              end
            end
          end
        end
      end
      default: next_st = sbs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wa <= 8'h0;
      wv <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      wa <= next_wa;
      wv <= next_wv;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= sbs_pkg::ST_IDLE;
      op <= 3'h0;
      sz <= 2'h0;
      memd <= 1'b0;
      iterate_prefix <= 1'b0;
      a16 <= 1'b0;
      sext <= 1'b0;
      accd <= 1'b0;
      bad <= 1'b0;
      dest <= 32'h0;
      src <= 32'h0;
      acc <= 32'h0;
      didx <= 32'h0;
      cnt <= 32'h0;
      flags <= `FLAGS_RST;
      env <= 9'h0;
      eslim <= 32'h0;
      sslim <= 32'h0;
      maddr <= 32'h0;
      tmp <= 32'h0;
      sc <= 5'h0;
      fault_valid <= 1'b0;
      fault_kind <= 2'h0;
      fault_err <= 1'b0;
    end
    else
    begin
      st <= next_st;
      op <= next_op;
      sz <= next_sz;
      memd <= next_memd;
      iterate_prefix <= next_rep;
      a16 <= next_a16;
      sext <= next_sext;
      accd <= next_accd;
      bad <= next_bad;
      dest <= next_dest;
      src <= next_src;
      acc <= next_acc;
      didx <= next_didx;
      cnt <= next_cnt;
      flags <= next_flags;
      env <= next_env;
      eslim <= next_eslim;
      sslim <= next_sslim;
      maddr <= next_maddr;
      tmp <= next_tmp;
      sc <= next_sc;
      fault_valid <= next_fv;
      fault_kind <= next_fk;
      fault_err <= next_fe;
    end
  end
endmodule : shift_borrow_scan_alu
`default_nettype wire
